// >>> tsp_engine.sv
`timescale 1ns/1ps
// packet protocol engine with apb register port
module tsp_engine import tsp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  // whole engine state
  typedef struct packed {
    tsp_rx_t rx_st; // receive sequencer
    logic [7:0] rx_flag; // flag of packet in flight
    logic [7:0] rx_len; // payload count
    logic [7:0] rx_idx; // payload index
    logic [7:0] rx_lo; // pending low byte
    logic [15:0] rx_sum; // running checksum
    logic [7:0] rx_ckl; // received checksum low
    logic [7:0] cmd_op, cmd_mod, cmd_unit, cmd_sw; // command fields
    logic [15:0] cmd_cnt, cmd_blk; // requested count, block
    logic [15:0] act_cnt; // bytes handled
    logic paced, credit, xoff; // reply pacing
    logic proto_err, cmd_pend, wdata_rdy, boot_req;
    logic [7:0] boot_unit;
    logic cont_req, end_req, data_req, raw_req; // send requests
    logic [7:0] raw_byte, data_len, end_code;
    logic [3:0] end_sumh; // summary bits 7:4
    tsp_tx_t tx_st; // transmit sequencer
    tsp_kind_t tx_kind;
    logic tx_raw; // bypass handshake
    logic [7:0] tx_single, tx_idx, tx_len, tx_lo;
    logic [15:0] tx_sum;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [BUF_AW-1:0] ptr; // software buffer pointer
    logic apb_ph, pready, pslverr;
    logic [31:0] prdata;
  } tsp_state_t;

  tsp_state_t s, n; // state, next_ state copy
  tsp_buf_if b(); // buffer port
  logic apb_done; // access completes this edge
  logic hit; // address decodes
  logic [31:0] rd_val; // read mux
  logic [7:0] tbyte; // byte being formed
  logic [15:0] rx_word; // received checksum word
  logic gate; // transmit allowed
  logic [7:0] sumh; // summary status high
  logic credit_set; // continue or xon taken this edge

  tsp_buf #(.DEPTH(1 << BUF_AW)) u_buf (.pclk(pclk), .bus(b.mem));

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign tx_data = s.tx_data;
  assign tx_valid = s.tx_valid;

  // combined next state
  always_comb begin
    n = s;
    b.wr_en = 1'b0;
    b.wr_addr = s.ptr;
    b.wr_data = pwdata[7:0];
    b.rd_addr = s.ptr;
    apb_done = psel & penable & s.pready;
    rx_word = {rx_data, s.rx_ckl};
    // any-error bit follows the others; low nibble zero
    sumh = {s.end_sumh[3] | (|s.end_sumh[2:0]), s.end_sumh[2:0], 4'h0};
    gate = s.tx_raw | (~s.xoff & (~s.paced | s.credit));
    tbyte = 8'h00;
    credit_set = 1'b0;
    // address decode and read mux
    hit = 1'b1;
    case (paddr)
      REG_ACTION: rd_val = {28'h000_0000, s.raw_req, s.end_req,
                            s.cont_req, s.data_req};
      REG_END: rd_val = {20'h0_0000, s.end_sumh, s.end_code};
      REG_BUF: rd_val = {24'h00_0000, b.rd_data};
      REG_PTR: rd_val = {25'h000_0000, s.ptr};
      REG_CMD: rd_val = {s.cmd_sw, s.cmd_unit, s.cmd_mod, s.cmd_op};
      REG_COUNT: rd_val = {s.act_cnt, s.cmd_cnt};
      REG_BLOCK: rd_val = {16'h0000, s.cmd_blk};
      REG_STATUS: rd_val = {16'h0000, s.boot_unit,
                            s.tx_st != TX_IDLE, s.boot_req, s.proto_err,
                            s.xoff, s.credit, s.paced, s.wdata_rdy,
                            s.cmd_pend};
      default: begin
        rd_val = RST_WORD;
        hit = 1'b0;
      end
    endcase
    // apb: setup, one wait cycle, then ready
    if (psel && !penable) begin
      n.apb_ph = 1'b1;
      n.pready = 1'b0;
    end else if (s.apb_ph) begin
      n.apb_ph = 1'b0;
      n.pready = 1'b1;
      n.prdata = rd_val;
      n.pslverr = ~hit;
    end else if (apb_done) begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    // register side effects at the completing edge
    if (apb_done && hit && pwrite) begin
      case (paddr)
        REG_ACTION: begin
          if (pwdata[ACT_DATA] && pwdata[ACT_LEN_LSB+:8] != 8'h00 &&
              pwdata[ACT_LEN_LSB+:8] <= MAX_PAYLOAD) begin
            n.data_req = 1'b1;
            n.data_len = pwdata[ACT_LEN_LSB+:8];
          end
          if (pwdata[ACT_CONT]) begin // buffer freed for host
            n.cont_req = 1'b1;
            n.wdata_rdy = 1'b0;
          end
          if (pwdata[ACT_END]) begin // end now, no padding
            n.end_req = 1'b1;
            n.data_req = 1'b0;
          end
          if (pwdata[ACT_RAW]) begin
            n.raw_req = 1'b1;
            n.raw_byte = pwdata[ACT_RAW_LSB+:8];
          end
        end
        REG_END: begin
          n.end_code = pwdata[7:0];
          n.end_sumh = pwdata[11:8];
        end
        REG_BUF: begin
          b.wr_en = 1'b1;
          n.ptr = s.ptr + 1'b1;
        end
        REG_PTR: n.ptr = pwdata[BUF_AW-1:0];
        REG_STATUS: if (pwdata[STAT_BOOT]) n.boot_req = 1'b0;
        default: ;
      endcase
    end
    if (apb_done && !pwrite && paddr == REG_BUF) begin
      n.ptr = s.ptr + 1'b1;
    end

    // receive sequencer
    if (rx_valid) begin
      case (s.rx_st)
        RX_IDLE: begin
          n.rx_flag = rx_data;
          n.rx_lo = rx_data;
          case (rx_data)
            FLAG_CONT, FLAG_XON: begin // release one paced byte
              n.credit = 1'b1;
              credit_set = 1'b1;
              n.xoff = 1'b0;
            end
            FLAG_XOFF: n.xoff = 1'b1;
            FLAG_INIT: begin // restart, answer continue
              n.proto_err = 1'b0;
              n.cont_req = 1'b1;
              n.end_req = 1'b0;
              n.data_req = 1'b0;
              n.cmd_pend = 1'b0;
              n.wdata_rdy = 1'b0;
            end
            FLAG_BOOT: n.rx_st = RX_BOOT;
            FLAG_CMD: n.rx_st = RX_CNT;
            // data only for a write awaiting it, one packet held
            FLAG_DATA: begin
              if (s.cmd_pend && s.cmd_op == 8'h03 && !s.wdata_rdy) begin
                n.rx_st = RX_CNT;
              end else begin
                n.proto_err = 1'b1;
              end
            end
            default: n.proto_err = 1'b1; // reserved flag bits
          endcase
        end
        RX_BOOT: begin
          n.boot_req = 1'b1;
          n.boot_unit = rx_data;
          n.rx_st = RX_IDLE;
        end
        RX_CNT: begin
          n.rx_len = rx_data;
          n.rx_idx = 8'h00;
          n.rx_sum = csum_add(16'h0000, {rx_data, s.rx_flag});
          n.rx_st = RX_BODY;
          if (s.rx_flag == FLAG_CMD ? rx_data != CMD_LEN :
              (rx_data == 8'h00 || rx_data > MAX_PAYLOAD)) begin
            n.proto_err = 1'b1;
            n.rx_st = RX_IDLE;
          end
        end
        RX_BODY: begin
          if (s.rx_flag == FLAG_DATA) begin
            b.wr_en = 1'b1;
            b.wr_addr = s.rx_idx[BUF_AW-1:0];
            b.wr_data = rx_data;
          end else begin
            case (s.rx_idx)
              8'h00: n.cmd_op = rx_data;
              8'h01: n.cmd_mod = rx_data;
              8'h02: n.cmd_unit = rx_data;
              8'h03: n.cmd_sw = rx_data;
              8'h06: n.cmd_cnt[7:0] = rx_data;
              8'h07: n.cmd_cnt[15:8] = rx_data;
              8'h08: n.cmd_blk[7:0] = rx_data;
              8'h09: n.cmd_blk[15:8] = rx_data;
              default: ;
            endcase
          end
          if (s.rx_idx[0]) begin // odd payload index pairs high
            n.rx_sum = csum_add(s.rx_sum, {rx_data, s.rx_lo});
          end else begin
            n.rx_lo = rx_data;
          end
          n.rx_idx = s.rx_idx + 8'h01;
          if (s.rx_idx == s.rx_len - 8'h01) n.rx_st = RX_CKL;
        end
        RX_CKL: begin
          n.rx_ckl = rx_data;
          if (s.rx_len[0]) begin // lone last byte, zero high
            n.rx_sum = csum_add(s.rx_sum, {8'h00, s.rx_lo});
          end
          n.rx_st = RX_CKH;
        end
        RX_CKH: begin
          n.rx_st = RX_IDLE;
          if (rx_word != s.rx_sum) begin
            n.proto_err = 1'b1;
          end else if (s.rx_flag == FLAG_DATA) begin
            n.wdata_rdy = 1'b1;
            n.ptr = '0;
            n.act_cnt = s.act_cnt + {8'h00, s.rx_len};
          end else begin
            // paced mode latched; first selection grants a byte
            n.paced = s.cmd_sw[SW_PACED_BIT];
            if (s.cmd_sw[SW_PACED_BIT] && !s.paced) n.credit = 1'b1;
            n.act_cnt = 16'h0000;
            n.data_req = 1'b0;
            if (op_legal(s.cmd_op)) begin
              n.cmd_pend = 1'b1;
              n.end_code = SC_NORMAL;
              n.end_sumh = 4'h0;
            end else begin
              n.end_code = SC_BAD_OP;
              n.end_sumh = 4'h1;
              n.end_req = 1'b1;
            end
          end
        end
        default: n.rx_st = RX_IDLE;
      endcase
    end

    // transmit byte former
    case (s.tx_kind)
      K_SINGLE: tbyte = s.tx_single;
      K_DATA: begin
        if (s.tx_idx == 8'h00) tbyte = FLAG_DATA;
        else if (s.tx_idx == 8'h01) tbyte = s.tx_len;
        else tbyte = b.rd_data;
      end
      default: begin // end packet
        case (s.tx_idx)
          8'h00: tbyte = FLAG_CMD;
          8'h01: tbyte = CMD_LEN;
          8'h02: tbyte = END_OPCODE;
          8'h03: tbyte = s.end_code;
          8'h04: tbyte = {7'h00, s.cmd_unit[0]};
          8'h08: tbyte = s.act_cnt[7:0];
          8'h09: tbyte = s.act_cnt[15:8];
          8'h0B: tbyte = sumh;
          default: tbyte = 8'h00;
        endcase
      end
    endcase
    if (s.tx_kind != K_SINGLE) begin // checksum trails body
      if (s.tx_idx == s.tx_len + 8'h02) tbyte = s.tx_sum[7:0];
      if (s.tx_idx == s.tx_len + 8'h03) tbyte = s.tx_sum[15:8];
    end

    // transmit sequencer
    case (s.tx_st)
      TX_IDLE: begin
        n.tx_idx = 8'h00;
        n.tx_sum = 16'h0000;
        n.tx_raw = 1'b0;
        n.tx_kind = K_SINGLE;
        n.tx_st = TX_FETCH;
        if (s.proto_err) begin
          n.tx_single = FLAG_INIT; // repeated, still gated
        end else if (s.cont_req) begin
          n.tx_single = FLAG_CONT;
          n.cont_req = 1'b0;
        end else if (s.raw_req) begin
          n.tx_single = s.raw_byte;
          n.tx_raw = 1'b1;
          n.raw_req = 1'b0;
        end else if (s.end_req) begin // ends the exchange
          n.tx_kind = K_END;
          n.tx_len = CMD_LEN;
          n.end_req = 1'b0;
          n.cmd_pend = 1'b0;
        end else if (s.data_req) begin
          n.tx_kind = K_DATA;
          n.tx_len = s.data_len;
          n.data_req = 1'b0;
          n.act_cnt = s.act_cnt + {8'h00, s.data_len};
        end else begin
          n.tx_st = TX_IDLE;
        end
      end
      TX_FETCH: begin
        b.rd_addr = BUF_AW'(s.tx_idx - 8'h02);
        n.tx_st = TX_BYTE;
      end
      TX_BYTE: begin
        b.rd_addr = BUF_AW'(s.tx_idx - 8'h02); // keep byte while gated
        if (gate) begin // full rate: no wait between packets
          n.tx_data = tbyte;
          n.tx_valid = 1'b1;
          // a continue arriving now survives the spend
          n.credit = (s.tx_raw | credit_set) & n.credit;
          n.tx_st = TX_SEND;
          if (s.tx_idx < s.tx_len + 8'h02) begin
            if (s.tx_idx[0]) n.tx_sum = csum_add(s.tx_sum, {tbyte, s.tx_lo});
            else n.tx_lo = tbyte;
          end else if (s.tx_idx == s.tx_len + 8'h01 + 8'h01 &&
                       s.tx_len[0]) begin
            n.tx_sum = s.tx_sum;
          end
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          n.tx_valid = 1'b0;
          n.tx_idx = s.tx_idx + 8'h01;
          n.tx_st = (s.tx_kind == K_SINGLE ||
                     s.tx_idx == s.tx_len + 8'h03) ? TX_IDLE : TX_FETCH;
          if (s.tx_kind != K_SINGLE && s.tx_idx == s.tx_len + 8'h01 &&
              s.tx_len[0]) begin // lone last payload byte
            n.tx_sum = csum_add(s.tx_sum, {8'h00, s.tx_lo});
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_good_s;
    s.rx_st == RX_CKH && rx_valid && s.rx_flag == FLAG_CMD &&
      rx_word == s.rx_sum;
  endsequence
  sequence byte_start_s;
    s.tx_st == TX_BYTE && !s.tx_valid;
  endsequence

  bad_op_end_a: assert property (
    cmd_good_s ##0 !op_legal(s.cmd_op) |=> s.end_req &&
      s.end_code == SC_BAD_OP)
    else $error("bad op code gave no end request");
  paced_sel_a: assert property (
    cmd_good_s |=> s.paced == $past(s.cmd_sw[SW_PACED_BIT]))
    else $error("paced setting not taken from switch byte");
  paced_gate_a: assert property (
    $rose(s.tx_valid) && $past(s.paced) && !s.tx_raw |->
      $past(s.credit) && !$past(s.xoff))
    else $error("paced byte sent without continue");
  full_rate_a: assert property (
    byte_start_s ##0 (!s.paced && !s.xoff) |=> s.tx_valid)
    else $error("full rate byte held back");
  tx_hold_a: assert property (
    s.tx_valid && !tx_ready |=> s.tx_valid && $stable(s.tx_data))
    else $error("transmit byte dropped before accepted");
  data_flag_a: assert property (
    $rose(s.tx_valid) && s.tx_kind == K_DATA && s.tx_idx == 8'h00 |->
      s.tx_data == FLAG_DATA && s.tx_len <= MAX_PAYLOAD)
    else $error("data packet header wrong");
  end_head_a: assert property (
    $rose(s.tx_valid) && s.tx_kind == K_END && s.tx_idx == 8'h02 |->
      s.tx_data == END_OPCODE)
    else $error("end packet op code wrong");
  end_zero_a: assert property (
    $rose(s.tx_valid) && s.tx_kind == K_END && (s.tx_idx == 8'h05 ||
      s.tx_idx == 8'h06 || s.tx_idx == 8'h07 || s.tx_idx == 8'h0A) |->
      s.tx_data == 8'h00)
    else $error("end packet zero byte not zero");
  summary_a: assert property (
    $rose(s.tx_valid) && s.tx_kind == K_END && s.tx_idx == 8'h0B |->
      s.tx_data[3:0] == 4'h0 &&
      s.tx_data[7] == (|s.tx_data[6:4] | s.end_sumh[3]))
    else $error("summary status high byte malformed");
  abort_a: assert property (
    s.tx_st == TX_IDLE && s.end_req && !s.proto_err && !s.cont_req &&
      !s.raw_req |=> s.tx_kind == K_END ##1 !s.data_req)
    else $error("end packet did not preempt data");
endmodule : tsp_engine

// >>> tsp_pkg.sv
// Operation
// - command, data packets, then one end packet
// - failure sends end packet at once, no padding
// - data packet: flag 001, count 1-128, checksum
// - long transfers split; one packet buffered
// - full-rate read packets stream back to back
// - switch bit 3 selects paced mode, retained
// - first paced byte goes out unprompted
// - later paced bytes wait for continue or xon
// - protocol error repeats init, still paced
// - bootstrap bytes bypass the handshake
// - end packet after every operation or bad op code
// - end packet: fourteen bytes, fixed header
// - success code is a signed byte
// - unit in byte 4; byte 5, sequence zero
// - bytes 8-9 carry actual byte count
// - summary high bits 4-7 flag errors
// - op codes decoded; some reserved
// - unknown op code ends with bad op code
// - checksum: word sum with end-around carry
// - single-byte flag values fixed
package tsp_pkg;
  // flag bytes
  localparam logic [7:0] FLAG_DATA = 8'h01;
  localparam logic [7:0] FLAG_CMD = 8'h02;
  localparam logic [7:0] FLAG_INIT = 8'h04;
  localparam logic [7:0] FLAG_BOOT = 8'h08;
  localparam logic [7:0] FLAG_CONT = 8'h10;
  localparam logic [7:0] FLAG_XON = 8'h11;
  localparam logic [7:0] FLAG_XOFF = 8'h13;
  // packet layout
  localparam logic [7:0] CMD_LEN = 8'h0A;
  localparam logic [7:0] END_OPCODE = 8'h40;
  localparam logic [7:0] MAX_PAYLOAD = 8'h80;
  localparam int SW_PACED_BIT = 3;
  localparam int BUF_AW = 7;
  // success codes
  localparam logic [7:0] SC_NORMAL = 8'h00;
  localparam logic [7:0] SC_RETRY = 8'h01;
  localparam logic [7:0] SC_SELFTEST = 8'hFF;
  localparam logic [7:0] SC_END_MEDIUM = 8'hFE;
  localparam logic [7:0] SC_BAD_UNIT = 8'hF8;
  localparam logic [7:0] SC_NO_CART = 8'hF7;
  localparam logic [7:0] SC_WPROT = 8'hF5;
  localparam logic [7:0] SC_DATA_CHECK = 8'hEF;
  localparam logic [7:0] SC_SEEK = 8'hE0;
  localparam logic [7:0] SC_MOTOR = 8'hDF;
  localparam logic [7:0] SC_BAD_OP = 8'hD0;
  localparam logic [7:0] SC_BAD_BLOCK = 8'hC9;
  // register byte offsets
  localparam logic [11:0] REG_ACTION = 12'h000;
  localparam logic [11:0] REG_END = 12'h004;
  localparam logic [11:0] REG_BUF = 12'h008;
  localparam logic [11:0] REG_PTR = 12'h00C;
  localparam logic [11:0] REG_CMD = 12'h010;
  localparam logic [11:0] REG_COUNT = 12'h014;
  localparam logic [11:0] REG_BLOCK = 12'h018;
  localparam logic [11:0] REG_STATUS = 12'h01C;
  // action and status field positions
  localparam int ACT_DATA = 0;
  localparam int ACT_CONT = 1;
  localparam int ACT_END = 2;
  localparam int ACT_RAW = 3;
  localparam int ACT_RAW_LSB = 8;
  localparam int ACT_LEN_LSB = 16;
  localparam int STAT_BOOT = 6;
  // reset values
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // receive and transmit sequencer states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_CNT = 3'b001, RX_BODY = 3'b010,
    RX_CKL = 3'b011, RX_CKH = 3'b100, RX_BOOT = 3'b101
  } tsp_rx_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_FETCH = 2'b01, TX_BYTE = 2'b10, TX_SEND = 2'b11
  } tsp_tx_t;
  typedef enum logic [1:0] {
    K_SINGLE = 2'b00, K_DATA = 2'b01, K_END = 2'b10
  } tsp_kind_t;

  // word add with end-around carry
  function automatic logic [15:0] csum_add(input logic [15:0] a,
                                           input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]};
  endfunction : csum_add

  // defined op codes 0,1,2,3,5,7,8,9
  function automatic logic op_legal(input logic [7:0] op);
    case (op)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h08, 8'h09: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : op_legal
endpackage : tsp_pkg

// >>> tsp_buf_if.sv
`timescale 1ns/1ps
// one-packet buffer port bundle
interface tsp_buf_if;
  import tsp_pkg::*;
  logic wr_en; // write strobe
  logic [BUF_AW-1:0] wr_addr; // write address
  logic [7:0] wr_data; // write byte
  logic [BUF_AW-1:0] rd_addr; // read address
  logic [7:0] rd_data; // registered read byte
  modport eng (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : tsp_buf_if

// >>> tsp_buf.sv
`timescale 1ns/1ps
// single-port-write packet buffer, read data registered
module tsp_buf #(
  parameter int DEPTH = 128
) (
  input wire logic pclk,
  tsp_buf_if.mem bus
);
  logic [7:0] mem [DEPTH]; // byte storage

  // write and registered read
  always_ff @(posedge pclk) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    bus.rd_data <= mem[bus.rd_addr];
  end
endmodule : tsp_buf

// >>> tsp_host.sv
`timescale 1ns/1ps
// serial host side: collects device bytes, sends host bytes
module tsp_host (
  input wire logic pclk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic slow
);
  logic [7:0] got [$]; // bytes taken from the device
  logic ph = 1'b0; // stall phase when slow
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // slow host takes a byte every other cycle
  assign tx_ready = !slow || ph;
  // take a byte only where valid and ready meet
  always @(posedge pclk) begin
    ph <= !ph;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
  // one-cycle byte pulse; idle line shows the inverse
  task put(input logic [7:0] b);
    @(posedge pclk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : put
endmodule : tsp_host

// >>> test_tape_serial_packet_protocol.sv
`timescale 1ns/1ps
// bench: apb master plus serial host model
module test_tape_serial_packet_protocol;
  import tsp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic slow = 1'b0;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  tsp_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  tsp_host hst (.pclk(pclk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .slow(slow));
  // 50 mhz clock
  initial begin
    forever #10 pclk = ~pclk;
  end
  // verdict and end of run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // value compare
  task chk(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      n_errors++;
      $display("ERROR %0t exp %h got %h", $time, e, a);
    end
  endtask : chk
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // word sum with end-around carry, low byte first
  function automatic logic [15:0] ck(input logic [7:0] q[$]);
    logic [16:0] s;
    s = 17'h0_0000;
    for (int i = 0; i < q.size(); i += 2) begin
      s = s[15:0] + {q[i + 1 < q.size() ? i + 1 : i] &
          {8{i + 1 < q.size()}}, q[i]} + s[16];
    end
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ck
  // frame with checksum appended, compared byte by byte
  task frame(input logic [7:0] q[$]);
    logic [15:0] c;
    c = ck(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    for (int i = 0; i < 2000 && hst.got.size() < q.size(); i++) begin
      @(posedge pclk);
    end
    chk(q.size(), hst.got.size());
    foreach (q[i]) chk(q[i], hst.got[i]);
    hst.got.delete();
  endtask : frame
  // command packet from the host
  task cmd(input logic [7:0] op, input logic [7:0] sw);
    logic [7:0] q[$];
    logic [15:0] c;
    q = '{FLAG_CMD, CMD_LEN, op, 8'h00, 8'h00, sw, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00};
    c = ck(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) hst.put(q[i]);
  endtask : cmd
  // unmapped address is refused
  task t_err;
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(1, err);
    $display("test unmapped done");
  endtask : t_err
  // nop then end packet on request
  task t_nop;
    cmd(8'h00, 8'h00);
    repeat (4) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(1, rd[0]);
    apb(1'b1, REG_ACTION, 32'h0000_0004);
    frame('{8'h02, 8'h0A, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00});
    $display("test nop done");
  endtask : t_nop
  // undefined op code answered at once
  task t_badop;
    cmd(8'h0C, 8'h00);
    frame('{8'h02, 8'h0A, 8'h40, 8'hD0, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h90});
    $display("test bad op done");
  endtask : t_badop
  // data packet to a stalling host
  task t_data;
    slow <= 1'b1;
    apb(1'b1, REG_PTR, 32'h0000_0000);
    apb(1'b1, REG_BUF, 32'h0000_00AA);
    apb(1'b1, REG_BUF, 32'h0000_0055);
    apb(1'b1, REG_ACTION, 32'h0002_0001);
    frame('{8'h01, 8'h02, 8'hAA, 8'h55});
    slow <= 1'b0;
    $display("test data done");
  endtask : t_data
  // write command: continue, one data packet in, end packet out
  task t_write;
    logic [7:0] q[$];
    logic [15:0] c;
    cmd(8'h03, 8'h00);
    apb(1'b1, REG_ACTION, 32'h0000_0002);
    for (int i = 0; i < 40 && hst.got.size() < 1; i++) @(posedge pclk);
    chk(1, hst.got.size());
    chk(FLAG_CONT, hst.got[0]);
    hst.got.delete();
    q = '{FLAG_DATA, 8'h02, 8'h11, 8'h22};
    c = ck(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) hst.put(q[i]);
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(1, rd[1]);
    apb(1'b0, REG_BUF, 32'h0000_0000);
    chk(32'h0000_0011, rd);
    apb(1'b1, REG_ACTION, 32'h0000_0004);
    frame('{8'h02, 8'h0A, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h02, 8'h00, 8'h00, 8'h00});
    $display("test write done");
  endtask : t_write
  // protocol error repeats init until the host sends init
  task t_proto;
    hst.put(8'h20);
    repeat (20) @(posedge pclk);
    chk(FLAG_INIT, hst.got[0]);
    chk(FLAG_INIT, hst.got[1]);
    hst.put(FLAG_INIT);
    repeat (20) @(posedge pclk);
    chk(FLAG_CONT, hst.got[hst.got.size() - 1]);
    hst.got.delete();
    $display("test protocol error done");
  endtask : t_proto
  // paced replies released one byte per continue or xon
  task t_paced;
    logic [7:0] q[$];
    cmd(8'h00, 8'h08);
    repeat (4) @(posedge pclk);
    apb(1'b1, REG_ACTION, 32'h0000_0004);
    repeat (40) @(posedge pclk);
    chk(1, hst.got.size());
    for (int n = 2; n <= 14; n++) begin
      hst.put(n[0] ? FLAG_XON : FLAG_CONT);
      for (int i = 0; i < 40 && hst.got.size() < n; i++) @(posedge pclk);
      repeat (10) @(posedge pclk);
      chk(n, hst.got.size());
    end
    q = '{8'h02, 8'h0A, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00};
    frame(q);
    apb(1'b1, REG_ACTION, 32'h0000_5A08);
    repeat (20) @(posedge pclk);
    chk(1, hst.got.size());
    chk(8'h5A, hst.got[0]);
    hst.got.delete();
    $display("test paced done");
  endtask : t_paced
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_err();
    t_nop();
    t_badop();
    t_data();
    t_write();
    t_proto();
    t_paced();
    tally_and_finish();
  end
endmodule : test_tape_serial_packet_protocol
